// *** dofm_cmp.sv ***
`timescale 1ns/1ps
`include "dofm_consts.svh"
// hysteresis-free comparator: equality keeps the last decision
module dofm_cmp
    import dofm_pkg::*;
(
    input  wire logic                   clk,   // clock
    input  wire logic                   rst,   // sync reset
    input  wire logic [`DOFM_VAL_W-1:0] value, // compared quantity
    input  wire logic [`DOFM_VAL_W-1:0] limit, // threshold
    output logic                        above  // value above limit
);
    always_ff @(posedge clk) begin
        if (rst)
            above <= 1'b0;
        else if (value > limit)
            above <= 1'b1;
        else if (value < limit)
            above <= 1'b0;
    end
endmodule : dofm_cmp

// *** dofm_consts.svh ***
`ifndef DOFM_CONSTS_SVH
`define DOFM_CONSTS_SVH
`define DOFM_FUNC_W         4
`define DOFM_FUNC_RUN       4'h0
`define DOFM_FUNC_ARRIVE    4'h1
`define DOFM_FUNC_OVER      4'h2
`define DOFM_FUNC_CURWARN   4'h3
`define DOFM_FUNC_PIDERR    4'h4
`define DOFM_FUNC_FAULT     4'h5
`define DOFM_FUNC_LOSS      4'h6
`define DOFM_FUNC_BOOST     4'h7
`define DOFM_FUNC_LINK      4'h8
`define DOFM_FUNC_LOGIC     4'h9
`define DOFM_OUT_FUNC_RST   4'h0
`define DOFM_RELAY_FUNC_RST 4'h5
`define DOFM_POL_NO         1'h0
`define DOFM_POL_NC         1'h1
`define DOFM_RELAY_POL_RST  1'h1
`define DOFM_MON_FREQ       1'h0
`define DOFM_MON_CUR        1'h1
`define DOFM_VAL_W          16
`define DOFM_CUR_LOOP_MIN   16'h0FA0
`define DOFM_CUR_FULL       16'h07D0
`define DOFM_WD_W           14
`define DOFM_WD_MAX         14'h270F
`define DOFM_CLK_HZ         50000000
`define DOFM_WD_TICK_S      0.01
`define DOFM_WD_TICK_CYC    (`DOFM_CLK_HZ / 100)
`endif

// *** dofm_load.sv ***
`timescale 1ns/1ps
// lamps and relay coil wired straight to the terminals
module dofm_load (
    input  wire logic       pin11,     // terminal 11
    input  wire logic       pin12,     // terminal 12
    input  wire logic       relay_pin, // alarm relay
    output logic      [2:0] coil       // energised loads
);
    assign coil = {relay_pin, pin12, pin11};
endmodule : dofm_load

// *** dofm_mapper.sv ***
`timescale 1ns/1ps
`include "dofm_consts.svh"
module dofm_mapper
    import dofm_pkg::*;
(
    input  wire logic                   CLK,                 // 50 MHz
    input  wire logic                   RST,                 // sync reset
    input  wire logic                   RUN_STATE,           // drive running
    input  wire logic                   OUTPUT_ON,           // motor driven
    input  wire logic                   RAMPING,             // accel/decel
    input  wire logic [`DOFM_VAL_W-1:0] OUT_FREQ,            // output freq
    input  wire logic [`DOFM_VAL_W-1:0] SET_FREQ,            // target freq
    input  wire logic [`DOFM_VAL_W-1:0] MAX_FREQ,            // full scale
    input  wire logic [`DOFM_VAL_W-1:0] OUT_CURRENT,         // % rated x10
    input  wire logic [`DOFM_VAL_W-1:0] OVERLOAD_LEVEL,      // warn level
    input  wire logic [`DOFM_VAL_W-1:0] PID_ERROR,           // |SP-PV|
    input  wire logic [`DOFM_VAL_W-1:0] PID_DEV_LEVEL,       // deviation
    input  wire logic [`DOFM_VAL_W-1:0] FEEDBACK,            // process PV
    input  wire logic [`DOFM_VAL_W-1:0] feedback_high_limit, // PV high
    input  wire logic [`DOFM_VAL_W-1:0] feedback_low_limit,  // PV low
    input  wire logic [`DOFM_VAL_W-1:0] VOLT_IN,             // voltage in
    input  wire logic [`DOFM_VAL_W-1:0] input_loss_level,    // loss level
    input  wire logic [`DOFM_VAL_W-1:0] CUR_IN_UA,           // loop uA
    input  wire logic                   FAULT_EVENT,         // trip pulse
    input  wire logic                   FAULT_CLEAR,         // reset pulse
    input  wire logic                   LINK_ACTIVITY,       // frame seen
    input  wire logic [`DOFM_WD_W-1:0]  watchdog_period,     // x10 ms
    input  wire logic                   boolean_result,      // logic op
    input  dofm_func_t                  out11_function_select, // [11]
    input  dofm_func_t                  out12_function_select, // [12]
    input  dofm_func_t                  relay_function_select, // relay
    input  wire logic                   out11_polarity,      // [11] NC
    input  wire logic                   out12_polarity,      // [12] NC
    input  wire logic                   relay_polarity,      // relay NC
    input  wire logic                   monitor_source_select, // 0 f 1 I
    input  wire logic                   CFG_LOAD,            // apply cfg
    output logic                        OUT11,               // terminal 11
    output logic                        OUT12,               // terminal 12
    output logic                        RELAY,               // alarm relay
    output logic [`DOFM_VAL_W-1:0]      monitor_output,      // 0..FFFF
    output logic                        fault_flag,          // latched
    output logic                        link_timeout_flag    // watchdog
);
    // ------------------------------------------------------------
    // configuration held in the block, loaded on CFG_LOAD
    // ------------------------------------------------------------
    dofm_cfg_t cfg11;
    dofm_cfg_t cfg12;
    dofm_cfg_t cfg_ry;
    logic      mon_sel;

    // range check: codes above 09 are refused, old setting kept
    function automatic logic dofm_valid(input dofm_func_t f);
        return f <= `DOFM_FUNC_LOGIC;
    endfunction : dofm_valid

    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg11 <= '{`DOFM_OUT_FUNC_RST, `DOFM_POL_NO};
            cfg12 <= '{`DOFM_OUT_FUNC_RST, `DOFM_POL_NO};
            cfg_ry <= '{`DOFM_RELAY_FUNC_RST, `DOFM_RELAY_POL_RST};
        end else if (CFG_LOAD) begin
            if (dofm_valid(out11_function_select))
                cfg11.func <= out11_function_select;
            if (dofm_valid(out12_function_select))
                cfg12.func <= out12_function_select;
            if (dofm_valid(relay_function_select))
                cfg_ry.func <= relay_function_select;
            cfg11.polarity <= out11_polarity;
            cfg12.polarity <= out12_polarity;
            cfg_ry.polarity <= relay_polarity;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST)
            mon_sel <= `DOFM_MON_FREQ;
        else if (CFG_LOAD)
            mon_sel <= monitor_source_select;
    end

    // ------------------------------------------------------------
    // threshold comparisons
    // ------------------------------------------------------------
    logic over_load;
    logic pid_excess;

    dofm_cmp u_cmp_ol (
        .clk   (CLK),
        .rst   (RST),
        .value (OUT_CURRENT),
        .limit (OVERLOAD_LEVEL),
        .above (over_load)
    );

    dofm_cmp u_cmp_od (
        .clk   (CLK),
        .rst   (RST),
        .value (PID_ERROR),
        .limit (PID_DEV_LEVEL),
        .above (pid_excess)
    );

    // ------------------------------------------------------------
    // frequency arrival
    // ------------------------------------------------------------
    logic reached;
    logic over_speed;

    always_ff @(posedge CLK) begin
        if (RST)
            reached <= 1'b0;
        else
            reached <= OUTPUT_ON && !RAMPING
                       && OUT_FREQ == SET_FREQ;
    end

    always_ff @(posedge CLK) begin
        if (RST)
            over_speed <= 1'b0;
        else
            over_speed <= OUTPUT_ON && OUT_FREQ >= SET_FREQ;
    end

    // ------------------------------------------------------------
    // fault latch: a new trip wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST)
            fault_flag <= 1'b0;
        else if (FAULT_EVENT)
            fault_flag <= 1'b1;
        else if (FAULT_CLEAR)
            fault_flag <= 1'b0;
    end

    // ------------------------------------------------------------
    // analog input loss
    // ------------------------------------------------------------
    logic loss;

    always_ff @(posedge CLK) begin
        if (RST)
            loss <= 1'b0;
        else
            loss <= VOLT_IN < input_loss_level
                    || CUR_IN_UA < `DOFM_CUR_LOOP_MIN;
    end

    // ------------------------------------------------------------
    // second stage output: set low, clear high or stop
    // ------------------------------------------------------------
    logic boost;

    always_ff @(posedge CLK) begin
        if (RST)
            boost <= 1'b0;
        else if (!RUN_STATE || FEEDBACK > feedback_high_limit)
            boost <= 1'b0;
        else if (FEEDBACK < feedback_low_limit)
            boost <= 1'b1;
    end

    // ------------------------------------------------------------
    // link watchdog, counted in 10 ms ticks
    // ------------------------------------------------------------
    localparam int TICK_CYC = `DOFM_WD_TICK_CYC;
    logic [19:0]            tick_cnt;
    logic                   tick;
    logic [`DOFM_WD_W-1:0]  wd_cnt;
    logic [`DOFM_WD_W-1:0]  wd_limit;

    // period 0 disables the watchdog; clamp at 99.99 s
    assign wd_limit = (watchdog_period > `DOFM_WD_MAX)
                      ? `DOFM_WD_MAX : watchdog_period;
    assign tick = tick_cnt == 20'(TICK_CYC - 1);

    always_ff @(posedge CLK) begin
        if (RST || LINK_ACTIVITY || tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 20'h00001;
    end

    always_ff @(posedge CLK) begin
        if (RST || LINK_ACTIVITY)
            wd_cnt <= '0;
        else if (tick && wd_cnt != wd_limit)
            wd_cnt <= wd_cnt + 14'h0001;
    end

    always_ff @(posedge CLK) begin
        if (RST || LINK_ACTIVITY || wd_limit == '0)
            link_timeout_flag <= 1'b0;
        else if (wd_cnt == wd_limit)
            link_timeout_flag <= 1'b1;
    end

    // ------------------------------------------------------------
    // status vector and output selection
    // ------------------------------------------------------------
    dofm_status_t status;

    always_comb begin
        status.run                   = RUN_STATE;
        status.speed_reached_flag    = reached;
        status.over_speed_flag       = over_speed;
        status.current_warning_flag  = over_load;
        status.pid_error_excess_flag = pid_excess;
        status.fault_flag            = fault_flag;
        status.input_loss_flag       = loss;
        status.pid_boost_stage_flag  = boost;
        status.link_timeout_flag     = link_timeout_flag;
        status.logic_result          = boolean_result;
    end

    dofm_sel u_sel11 (
        .clk    (CLK),
        .rst    (RST),
        .status (status),
        .cfg    (cfg11),
        .pin    (OUT11)
    );

    dofm_sel u_sel12 (
        .clk    (CLK),
        .rst    (RST),
        .status (status),
        .cfg    (cfg12),
        .pin    (OUT12)
    );

    dofm_sel u_selry (
        .clk    (CLK),
        .rst    (RST),
        .status (status),
        .cfg    (cfg_ry),
        .pin    (RELAY)
    );

    // ------------------------------------------------------------
    // monitor scaling to 16-bit full scale
    // ------------------------------------------------------------
    // current input is tenths of a percent; 2000 = 200% full scale
    localparam logic [`DOFM_VAL_W-1:0] CUR_FULL = `DOFM_CUR_FULL;
    logic [31:0] num;
    logic [`DOFM_VAL_W-1:0] den;
    logic [`DOFM_VAL_W-1:0] src;
    logic [31:0] quo;

    always_comb begin
        if (mon_sel == `DOFM_MON_CUR) begin
            src = OUT_CURRENT;
            den = CUR_FULL;
        end else begin
            src = OUT_FREQ;
            den = MAX_FREQ;
        end
        num = {src, 16'h0000} - {16'h0000, src};
        // divider is costly; a clamp handles over-range input
        quo = (den == '0) ? 32'h00000000 : num / {16'h0000, den};
    end

    always_ff @(posedge CLK) begin
        if (RST)
            monitor_output <= '0;
        else if (src >= den)
            monitor_output <= 16'hFFFF;
        else
            monitor_output <= quo[15:0];
    end
endmodule : dofm_mapper

// *** dofm_mapper_props.sv ***
`timescale 1ns/1ps
`include "dofm_consts.svh"
module dofm_mapper_props
    import dofm_pkg::*;
(
    input wire logic        CLK,                   // clock
    input wire logic        RST,                   // sync reset
    input wire logic        RUN_STATE,             // running
    input wire logic        OUTPUT_ON,             // motor on
    input wire logic        RAMPING,               // ramp
    input wire logic [15:0] OUT_FREQ,              // output freq
    input wire logic [15:0] SET_FREQ,              // target freq
    input wire logic        FAULT_EVENT,           // trip
    input wire logic        FAULT_CLEAR,           // clear
    input wire logic        LINK_ACTIVITY,         // frame seen
    input wire logic [13:0] watchdog_period,       // x10 ms
    input wire logic        boolean_result,        // logic op
    input dofm_func_t       out11_function_select, // [11] func
    input wire logic        out11_polarity,        // [11] NC
    input wire logic        CFG_LOAD,              // apply cfg
    input wire logic        OUT11,                 // terminal 11
    input wire logic        fault_flag,            // fault
    input wire logic        link_timeout_flag      // watchdog
);
    // --------------------
    // shadow of [11] setup
    // --------------------
    dofm_func_t f11;
    logic       p11;
    logic       fa1;
    // codes above nine are dropped, as the device does
    always_ff @(posedge CLK) begin
        if (RST) begin
            f11 <= `DOFM_OUT_FUNC_RST;
        end else if (CFG_LOAD && out11_function_select < 4'hA) begin
            f11 <= out11_function_select;
        end
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            p11 <= `DOFM_POL_NO;
        end else if (CFG_LOAD) begin
            p11 <= out11_polarity;
        end
    end
    always_ff @(posedge CLK) begin
        fa1 <= !RST && OUTPUT_ON && !RAMPING && OUT_FREQ == SET_FREQ;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_trip;
        FAULT_EVENT ##1 fault_flag;
    endsequence
    AST_FAULT_SET: assert property (FAULT_EVENT |-> s_trip)
        else $error("fault not latched");
    AST_FAULT_CLR: assert property (
        FAULT_CLEAR && !FAULT_EVENT |=> !fault_flag)
        else $error("fault not cleared");
    AST_LINK_CLR: assert property (
        LINK_ACTIVITY |=> !link_timeout_flag)
        else $error("timeout after activity");
    AST_WD_OFF: assert property (
        watchdog_period == 0 |=> !link_timeout_flag)
        else $error("timeout while disabled");
    AST_RUN_MAP: assert property (f11 == `DOFM_FUNC_RUN
        |=> OUT11 == ($past(RUN_STATE) ^ $past(p11)))
        else $error("run pin");
    AST_FAULT_MAP: assert property (f11 == `DOFM_FUNC_FAULT
        |=> OUT11 == ($past(fault_flag) ^ $past(p11)))
        else $error("fault pin");
    AST_ARRIVE_MAP: assert property (f11 == `DOFM_FUNC_ARRIVE
        |=> OUT11 == ($past(fa1) ^ $past(p11)))
        else $error("arrive pin");
    AST_LOGIC_MAP: assert property (f11 == `DOFM_FUNC_LOGIC
        |=> OUT11 == ($past(boolean_result) ^ $past(p11)))
        else $error("logic pin");
endmodule : dofm_mapper_props

// *** dofm_mapper_tb.sv ***
`timescale 1ns/1ps
`include "dofm_consts.svh"
bind dofm_mapper dofm_mapper_props dofm_mapper_props_inst (.CLK, .RST,
    .RUN_STATE, .OUTPUT_ON, .RAMPING, .OUT_FREQ, .SET_FREQ, .FAULT_EVENT,
    .FAULT_CLEAR, .LINK_ACTIVITY, .watchdog_period, .boolean_result,
    .out11_function_select, .out11_polarity, .CFG_LOAD, .OUT11,
    .fault_flag, .link_timeout_flag);
module dofm_mapper_tb;
    import dofm_pkg::*;
    logic CLK = 1'b0;
    logic RST, RUN_STATE, OUTPUT_ON, RAMPING, FAULT_EVENT, FAULT_CLEAR;
    logic LINK_ACTIVITY, boolean_result, CFG_LOAD, monitor_source_select;
    logic out11_polarity, out12_polarity, relay_polarity;
    logic OUT11, OUT12, RELAY, fault_flag, link_timeout_flag;
    logic [15:0] OUT_FREQ, SET_FREQ, MAX_FREQ, OUT_CURRENT, OVERLOAD_LEVEL;
    logic [15:0] PID_ERROR, PID_DEV_LEVEL, FEEDBACK, feedback_high_limit;
    logic [15:0] feedback_low_limit, VOLT_IN, input_loss_level, CUR_IN_UA;
    logic [15:0] monitor_output;
    logic [13:0] watchdog_period;
    dofm_func_t  out11_function_select, out12_function_select;
    dofm_func_t  relay_function_select;
    logic [2:0]  coil;
    logic [41:0] notes[$];
    logic [41:0] note;
    logic [20:0] obs;
    logic [31:0] v, e, d;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cyc = 0;
    event        look;
    always #10 CLK = ~CLK;
    dofm_mapper dofm_mapper_inst (.CLK, .RST, .RUN_STATE, .OUTPUT_ON,
        .RAMPING, .OUT_FREQ, .SET_FREQ, .MAX_FREQ, .OUT_CURRENT,
        .OVERLOAD_LEVEL, .PID_ERROR, .PID_DEV_LEVEL, .FEEDBACK,
        .feedback_high_limit, .feedback_low_limit, .VOLT_IN,
        .input_loss_level, .CUR_IN_UA, .FAULT_EVENT, .FAULT_CLEAR,
        .LINK_ACTIVITY, .watchdog_period, .boolean_result,
        .out11_function_select, .out12_function_select,
        .relay_function_select, .out11_polarity, .out12_polarity,
        .relay_polarity, .monitor_source_select, .CFG_LOAD, .OUT11, .OUT12,
        .RELAY, .monitor_output, .fault_flag, .link_timeout_flag);
    dofm_load dofm_load_inst (.pin11(OUT11), .pin12(OUT12),
        .relay_pin(RELAY), .coil(coil));
    task step(input int n);
        repeat (n) @(negedge CLK);
    endtask : step
    task expect_obs(input logic [20:0] m, input logic [20:0] x);
        notes.push_back({m, x});
        -> look;
    endtask : expect_obs
    task pins(input logic [2:0] p);
        expect_obs(21'h070000, {2'b00, p, 16'h0000});
    endtask : pins
    // [11] plain, [12] inverted, relay plain: one pass covers both senses
    task cfg(input dofm_func_t f, input logic m);
        {out11_function_select, out12_function_select} = {f, f};
        relay_function_select = f;
        {out11_polarity, out12_polarity, relay_polarity} = 3'b010;
        monitor_source_select = m;
        CFG_LOAD = 1'b1;
        step(1);
        CFG_LOAD = 1'b0;
    endtask : cfg
    task drive(input int c, input logic a);
        case (c)
            0: RUN_STATE = a;
            1: {OUTPUT_ON, RAMPING, OUT_FREQ} = {1'b1, !a, SET_FREQ};
            2: begin
                RAMPING = 1'b1;
                OUT_FREQ = a ? SET_FREQ : SET_FREQ - 16'h0001;
            end
            3: OUT_CURRENT = a ? 16'h04B0 : 16'h0320;
            4: PID_ERROR = a ? 16'h0028 : 16'h0014;
            5: begin
                {FAULT_EVENT, FAULT_CLEAR} = {a, !a};
                step(1);
                {FAULT_EVENT, FAULT_CLEAR} = 2'b00;
            end
            6: begin
                CUR_IN_UA = a ? 16'h0F9F : 16'h0FA0;
                VOLT_IN = 16'h0200;
            end
            7: {RUN_STATE, FEEDBACK} = {1'b1, a ? 16'h000A : 16'h005A};
            8: begin
                {watchdog_period, LINK_ACTIVITY} = {14'h0000, 1'b1};
                step(1);
                LINK_ACTIVITY = 1'b0;
            end
            default: boolean_result = a;
        endcase
    endtask : drive
    task give_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // flags ride along so every top-level output is under comparison
    assign obs = {link_timeout_flag, fault_flag, coil, monitor_output};
    always @(look) begin
        note = notes.pop_front();
        check_count++;
        if ((obs & note[41:21]) !== note[20:0]) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp %h got %h", $time, note[20:0],
                     obs);
        end
    end
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'hD7D430A1));
        {RST, RUN_STATE, OUTPUT_ON, RAMPING, FAULT_EVENT} = 5'h10;
        {FAULT_CLEAR, LINK_ACTIVITY, boolean_result, CFG_LOAD} = 4'h0;
        {monitor_source_select, out11_polarity, out12_polarity} = 3'h0;
        relay_polarity = 1'b1;
        {out11_function_select, out12_function_select} = 8'h00;
        relay_function_select = 4'h5;
        {OUT_FREQ, SET_FREQ, OUT_CURRENT} = {16'h0000, 16'h01F4, 16'h0000};
        MAX_FREQ = 16'h0400 + 16'($urandom % 32'h400);
        {OVERLOAD_LEVEL, PID_ERROR, PID_DEV_LEVEL} = 48'h03E8_0000_001E;
        {FEEDBACK, feedback_high_limit} = {16'h0032, 16'h0050};
        {feedback_low_limit, input_loss_level} = {16'h0014, 16'h0064};
        {VOLT_IN, CUR_IN_UA, watchdog_period} = {16'h0200, 16'h1F40, 14'h1};
        step(8);
        RST = 1'b0;
        step(2);
        expect_obs(21'h1FFFFF, 21'h040000);
        for (int c = 0; c < 10; c++) begin
            cfg(c[3:0], 1'b0);
            for (int a = 1; a >= 0; a--) begin
                if (c != 8 || a == 0) begin
                    drive(c, a[0]);
                    step(3);
                    pins({a[0], !a[0], a[0]});
                end
                // equal to threshold must keep the active state; input loss stays set by VOLT_IN below its level
                if (a == 1 && (c == 3 || c == 4 || c == 6)) begin
                    {OUT_CURRENT, PID_ERROR} = {OVERLOAD_LEVEL, PID_DEV_LEVEL};
                    {CUR_IN_UA, VOLT_IN} = {16'h0FA0, 16'h0010};
                    step(3);
                    pins(3'b101);
                end
            end
        end
        cfg(4'hC, 1'b0);
        boolean_result = 1'b1;
        step(3);
        pins(3'b101);
        cfg(4'h5, 1'b0);
        {FAULT_EVENT, FAULT_CLEAR} = 2'b11;
        step(1);
        {FAULT_EVENT, FAULT_CLEAR} = 2'b00;
        step(3);
        expect_obs(21'h1F0000, 21'h0D0000);
        for (int i = 0; i < 4; i++) begin
            v = $urandom % 32'h9C4;
            d = i[0] ? 32'h7D0 : {16'h0000, MAX_FREQ};
            e = (v >= d) ? 32'hFFFF : v * 32'hFFFF / d;
            cfg(4'h5, i[0]);
            {OUT_FREQ, OUT_CURRENT} = {v[15:0], v[15:0]};
            step(3);
            expect_obs(21'h00FFFF, {5'b00000, e[15:0]});
        end
        step(1);
        give_verdict();
    end
endmodule : dofm_mapper_tb

// *** dofm_pkg.sv ***
package dofm_pkg;
`include "dofm_consts.svh"
    typedef logic [`DOFM_FUNC_W-1:0] dofm_func_t;
    // one bit per status function, indexed by function code
    typedef struct packed {
        logic logic_result;
        logic link_timeout_flag;
        logic pid_boost_stage_flag;
        logic input_loss_flag;
        logic fault_flag;
        logic pid_error_excess_flag;
        logic current_warning_flag;
        logic over_speed_flag;
        logic speed_reached_flag;
        logic run;
    } dofm_status_t;
    typedef struct packed {
        dofm_func_t func;
        logic       polarity;
    } dofm_cfg_t;
endpackage : dofm_pkg

// *** dofm_sel.sv ***
`timescale 1ns/1ps
`include "dofm_consts.svh"
module dofm_sel
    import dofm_pkg::*;
(
    input  wire logic         clk,    // clock
    input  wire logic         rst,    // sync reset
    input  dofm_status_t      status, // status functions
    input  dofm_cfg_t         cfg,    // function and polarity
    output logic              pin     // output level
);
    logic chosen;

    always_comb begin
        if (cfg.func <= `DOFM_FUNC_LOGIC)
            chosen = status[cfg.func];
        else
            chosen = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst)
            pin <= 1'b0;
        else
            pin <= chosen ^ cfg.polarity;
    end
endmodule : dofm_sel
